// File: src/ags_pkg.sv
package ags_pkg;
    // ************************************************************
    // value ranges
    // ************************************************************
    localparam int unsigned ADC_WIDTH    = 12;
    localparam int unsigned AIN_WIDTH    = 11;
    localparam logic [10:0] AIN_MAX      = 11'h3E8;    // 1000 counts at full scale
    localparam logic [11:0] ADC_FULL     = 12'hFFF;    // converter full scale code
    localparam int unsigned GAIN_WIDTH   = 10;
    localparam logic [9:0]  GAIN_MAX     = 10'h3E8;    // 10.00 in hundredths
    localparam logic [9:0]  GAIN_DIV     = 10'h064;    // 100 hundredths per unit
    localparam int unsigned OFS_WIDTH    = 15;
    localparam logic signed [14:0] OFS_MAX = 15'sh2710; // +10000
    localparam logic signed [14:0] OFS_MIN = -15'sh2710; // -10000
    localparam int unsigned OUT_WIDTH    = 16;
    localparam int unsigned PROD_WIDTH   = 21;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [9:0]  GAIN_RST     = 10'h064;    // gain 1.00
    localparam logic signed [14:0] OFS_RST = 15'sh0000;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [3:0]  ADDR_GAIN    = 4'h0;
    localparam logic [3:0]  ADDR_OFFSET  = 4'h4;
    localparam logic [3:0]  ADDR_INVERT  = 4'h8;
    localparam logic [3:0]  ADDR_VALUE   = 4'hC;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ags_bus_t;

    typedef enum logic [1:0] {
        AGS_IDLE  = 2'b00,
        AGS_SCALE = 2'b01,
        AGS_SUM   = 2'b11
    } ags_state_t;
endpackage

// File: src/ags_scaler.sv
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - map 0..full scale linearly onto 0..1000
// - clamp readings above full scale at 1000
// - value equals internal times gain plus offset
// - gain accepted 0.00 to 10.00 hundredths
// - offset accepted -10000 to +10000 inclusive
// - each logical input individually invertible
module ags_scaler #(
    parameter int unsigned NUM_INPUTS = 8
) (
    input  wire logic                                mclk,
    input  wire logic                                rstn,
    input  wire logic                                sampleValid,
    input  wire logic [ags_pkg::ADC_WIDTH-1:0]       sampleCode,
    input  wire logic [NUM_INPUTS-1:0]               logicIn,
    input  wire ags_pkg::ags_bus_t                   bus,
    output logic [31:0]                              rdata,
    output logic signed [ags_pkg::OUT_WIDTH-1:0]     scaled_actual_value,
    output logic                                     valueValid,
    output logic [NUM_INPUTS-1:0]                    logicOut
);
    // ************************************************************
    // helpers
    // ************************************************************
    // linear map of converter code onto 0..1000, clamped at the top
    function automatic logic [10:0] toInternal(input logic [11:0] code);
        logic [21:0] p;
        logic [21:0] q;
        p = 22'(code) * 22'(ags_pkg::AIN_MAX);
        q = p / 22'(ags_pkg::ADC_FULL);
        // guards against a converter whose full scale sits below its top code
        if (q > 22'(ags_pkg::AIN_MAX)) begin
            return ags_pkg::AIN_MAX;
        end
        return q[10:0];
    endfunction

    // ************************************************************
    // registers and datapath state
    // ************************************************************
    logic [9:0]                      gain_reg, gain_next;
    logic signed [14:0]              ofs_reg, ofs_next;
    logic [NUM_INPUTS-1:0]           inv_reg, inv_next;
    logic [10:0]                     ain_reg, ain_next;
    logic [15:0]                     whole_reg, whole_next;
    logic signed [15:0]              val_reg, val_next;
    logic                            vld_reg, vld_next;
    logic [NUM_INPUTS-1:0]           lout_reg, lout_next;
    logic [31:0]                     rd_reg, rd_next;
    ags_pkg::ags_state_t             st_reg, st_next;
    logic [20:0]                     prod;
    logic signed [14:0]              wOfs;

    assign prod = 21'(ain_reg) * 21'(gain_reg);
    assign wOfs = bus.wdata[14:0];

    // next values: register writes, reads, pipeline
    always_comb begin
        gain_next  = gain_reg;
        ofs_next   = ofs_reg;
        inv_next   = inv_reg;
        ain_next   = ain_reg;
        whole_next = whole_reg;
        val_next   = val_reg;
        vld_next   = 1'b0;
        st_next    = st_reg;
        rd_next    = 32'h00000000;
        lout_next  = logicIn ^ inv_reg;
        if (bus.wr) begin
            case (bus.addr)
                ags_pkg::ADDR_GAIN: begin
                    if (bus.wdata[31:10] == 22'h000000 && bus.wdata[9:0] <= ags_pkg::GAIN_MAX) begin
                        gain_next = bus.wdata[9:0];
                    end
                end
                ags_pkg::ADDR_OFFSET: begin
                    if (wOfs >= ags_pkg::OFS_MIN && wOfs <= ags_pkg::OFS_MAX) begin
                        ofs_next = wOfs;
                    end
                end
                ags_pkg::ADDR_INVERT: inv_next = bus.wdata[NUM_INPUTS-1:0];
                default: ;
            endcase
        end
        if (bus.rd) begin
            case (bus.addr)
                ags_pkg::ADDR_GAIN:   rd_next = {22'h000000, gain_reg};
                ags_pkg::ADDR_OFFSET: rd_next = {{17{ofs_reg[14]}}, ofs_reg};
                ags_pkg::ADDR_INVERT: rd_next = 32'(inv_reg);
                ags_pkg::ADDR_VALUE:  rd_next = {{16{val_reg[15]}}, val_reg};
                default:              rd_next = 32'h00000000;
            endcase
        end
        case (st_reg)
            ags_pkg::AGS_IDLE: begin
                if (sampleValid) begin
                    ain_next = toInternal(sampleCode);
                    st_next  = ags_pkg::AGS_SCALE;
                end
            end
            ags_pkg::AGS_SCALE: begin
                whole_next = 16'(prod / 21'(ags_pkg::GAIN_DIV));
                st_next    = ags_pkg::AGS_SUM;
            end
            ags_pkg::AGS_SUM: begin
                val_next = $signed(whole_reg) + 16'(ofs_reg);
                vld_next = 1'b1;
                st_next  = ags_pkg::AGS_IDLE;
            end
            default: st_next = ags_pkg::AGS_IDLE;
        endcase
    end

    // register all state
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            gain_reg  <= ags_pkg::GAIN_RST;
            ofs_reg   <= ags_pkg::OFS_RST;
            inv_reg   <= '0;
            ain_reg   <= 11'h000;
            whole_reg <= 16'h0000;
            val_reg   <= 16'sh0000;
            vld_reg   <= 1'b0;
            lout_reg  <= '0;
            rd_reg    <= 32'h00000000;
            st_reg    <= ags_pkg::AGS_IDLE;
        end else begin
            gain_reg  <= gain_next;
            ofs_reg   <= ofs_next;
            inv_reg   <= inv_next;
            ain_reg   <= ain_next;
            whole_reg <= whole_next;
            val_reg   <= val_next;
            vld_reg   <= vld_next;
            lout_reg  <= lout_next;
            rd_reg    <= rd_next;
            st_reg    <= st_next;
        end
    end

    assign rdata               = rd_reg;
    assign scaled_actual_value = val_reg;
    assign valueValid          = vld_reg;
    assign logicOut            = lout_reg;

    // ************************************************************
    // checks
    // ************************************************************
    sequence seqSample;
        st_reg == ags_pkg::AGS_IDLE && sampleValid;
    endsequence

    chk_ain_range: assert property (@(posedge mclk) disable iff (!rstn)
        ain_reg <= ags_pkg::AIN_MAX) else $error("internal value above 1000");
    chk_full_clamp: assert property (@(posedge mclk) disable iff (!rstn)
        seqSample and sampleCode == ags_pkg::ADC_FULL |=> ain_reg == ags_pkg::AIN_MAX)
        else $error("full scale not 1000");
    chk_value_math: assert property (@(posedge mclk) disable iff (!rstn)
        seqSample |=> ##2 valueValid && val_reg ==
            $signed(16'($past(prod, 2) / 21'(ags_pkg::GAIN_DIV))) + 16'($past(ofs_reg)))
        else $error("scaled value wrong");
    chk_gain_range: assert property (@(posedge mclk) disable iff (!rstn)
        gain_reg <= ags_pkg::GAIN_MAX) else $error("gain above 10.00");
    chk_ofs_range: assert property (@(posedge mclk) disable iff (!rstn)
        ofs_reg >= ags_pkg::OFS_MIN && ofs_reg <= ags_pkg::OFS_MAX)
        else $error("offset out of range");
    chk_input_invert: assert property (@(posedge mclk) disable iff (!rstn)
        ##1 logicOut == ($past(logicIn) ^ $past(inv_reg))) else $error("inversion wrong");
    chk_trunc_whole: assert property (@(posedge mclk) disable iff (!rstn)
        st_reg == ags_pkg::AGS_SCALE |=>
            21'(whole_reg) * 21'(ags_pkg::GAIN_DIV) <= $past(prod)
            && $past(prod) < 21'(whole_reg) * 21'(ags_pkg::GAIN_DIV) + 21'(ags_pkg::GAIN_DIV))
        else $error("product not truncated");
    chk_read_lat: assert property (@(posedge mclk) disable iff (!rstn)
        bus.rd && bus.addr == ags_pkg::ADDR_GAIN |=> rdata == {22'h000000, $past(gain_reg)})
        else $error("gain readback wrong");

    // read data stands only in the cycle after a read strobe
    chk_rd_quiet: assert property (@(posedge mclk) disable iff (!rstn)
        !bus.rd |=> rdata == 32'h00000000)
        else $error("read data outside read slot");

    // refused gain writes leave the setting alone
    chk_gain_refuse: assert property (@(posedge mclk) disable iff (!rstn)
        bus.wr && bus.addr == ags_pkg::ADDR_GAIN && bus.wdata > 32'(ags_pkg::GAIN_MAX)
        |=> $stable(gain_reg))
        else $error("out of range gain taken");

    // accepted gain writes land one cycle later
    chk_gain_accept: assert property (@(posedge mclk) disable iff (!rstn)
        bus.wr && bus.addr == ags_pkg::ADDR_GAIN && bus.wdata <= 32'(ags_pkg::GAIN_MAX)
        |=> gain_reg == $past(bus.wdata[9:0]))
        else $error("gain write lost");

    // refused offset writes leave the setting alone
    chk_ofs_refuse: assert property (@(posedge mclk) disable iff (!rstn)
        bus.wr && bus.addr == ags_pkg::ADDR_OFFSET
        && (wOfs > ags_pkg::OFS_MAX || wOfs < ags_pkg::OFS_MIN) |=> $stable(ofs_reg))
        else $error("out of range offset taken");

    // accepted offset writes land one cycle later
    chk_ofs_accept: assert property (@(posedge mclk) disable iff (!rstn)
        bus.wr && bus.addr == ags_pkg::ADDR_OFFSET
        && wOfs <= ags_pkg::OFS_MAX && wOfs >= ags_pkg::OFS_MIN |=> ofs_reg == $past(wOfs))
        else $error("offset write lost");

    // bottom of the converter range maps onto zero
    chk_zero_map: assert property (@(posedge mclk) disable iff (!rstn)
        seqSample and sampleCode == 12'h000 |=> ain_reg == 11'h000)
        else $error("zero code not mapped to 0");

    // samples arriving while the pipeline is busy are dropped
    chk_busy_drop: assert property (@(posedge mclk) disable iff (!rstn)
        st_reg != ags_pkg::AGS_IDLE |=> $stable(ain_reg))
        else $error("sample taken while busy");

    // result pulse: two quiet cycles, one valid cycle, then quiet again
    sequence seqPipeline;
        !valueValid [*2] ##1 valueValid ##1 !valueValid;
    endsequence

    chk_result_latency: assert property (@(posedge mclk) disable iff (!rstn)
        seqSample |=> seqPipeline)
        else $error("result pulse timing wrong");

    // the shown value only moves together with its valid pulse
    chk_value_hold: assert property (@(posedge mclk) disable iff (!rstn)
        $changed(scaled_actual_value) |-> valueValid)
        else $error("value moved without valid pulse");
endmodule

// File: verif/ags_sensor_model.sv
`timescale 1ns/1ps
// ****************************************
// converter model: one-cycle sample pulses
// ****************************************
module ags_sensor_model (
    input  wire logic        mclk,
    input  wire logic        sampleReq,
    input  wire logic [11:0] reqCode,
    output logic             sampleValid,
    output logic [11:0]      sampleCode
);
    // code is only meaningful with the pulse; garbage between pulses
    always_ff @(posedge mclk) begin
        sampleValid <= sampleReq;
        sampleCode  <= sampleReq ? reqCode : ~sampleCode;
    end
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    // ****************************************
    // signals and bench model state
    // ****************************************
    logic              mclk, rstn, sampleReq, sampleValid, valueValid;
    logic [11:0]       reqCode, sampleCode;
    logic [7:0]        logicIn, logicOut;
    ags_pkg::ags_bus_t bus;
    logic [31:0]       rdata, rdV;
    logic signed [15:0] value;
    int                fails, tests_run, gainM, ofsM, mskM, n, i, c, g, o, e;
    int unsigned       seed;

    ags_sensor_model sens (.mclk(mclk), .sampleReq(sampleReq), .reqCode(reqCode),
        .sampleValid(sampleValid), .sampleCode(sampleCode));
    ags_scaler #(.NUM_INPUTS(8)) uut (.mclk(mclk), .rstn(rstn), .sampleValid(sampleValid),
        .sampleCode(sampleCode), .logicIn(logicIn), .bus(bus), .rdata(rdata),
        .scaled_actual_value(value), .valueValid(valueValid), .logicOut(logicOut));

    // clock at 125 MHz
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic int unsigned nxt();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one-cycle write; model follows only accepted values
    task automatic wr(input logic [3:0] a, input int d);
        @(posedge mclk);
        bus.addr <= a; bus.wdata <= d; bus.wr <= 1'b1;
        @(posedge mclk);
        bus.wr <= 1'b0;
        if (a == 4'h0 && d >= 0 && d <= 1000) gainM = d;
        if (a == 4'h4 && d >= -10000 && d <= 10000) ofsM = d;
        if (a == 4'h8) mskM = d & 8'hFF;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        bus.addr <= a; bus.rd <= 1'b1;
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1 rdV = rdata;
    endtask
    // one conversion, waited for under a bound
    task automatic conv(input int code);
        @(posedge mclk);
        sampleReq <= 1'b1; reqCode <= 12'(code);
        @(posedge mclk);
        sampleReq <= 1'b0;
        for (n = 0; n < 8 && valueValid !== 1'b1; n++) @(posedge mclk) #1;
        // a bound that runs out counts as a mismatch; the run goes on to the report
        if (n == 8) fails++;
        e = code * 1000 / 4095;
        if (e > 1000) e = 1000;
        e = e * gainM / 100 + ofsM;
        check(n, 3);
        check({{16{value[15]}}, value}, e);
        @(posedge mclk) #1;
        check(valueValid, 1'b0);
        rd(4'hC);
        check(rdV, e);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rstn = 1'b0; sampleReq = 1'b0; reqCode = '0; logicIn = '0; bus = '0;
        seed = 95840; fails = 0; tests_run = 0; gainM = 100; ofsM = 0; mskM = 0;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        rd(4'h0); check(rdV, 32'h64);
        rd(4'h4); check(rdV, 32'h0);
        rd(4'h2); check(rdV, 32'h0);
        $display("test reset done");
        wr(4'h0, 1001); rd(4'h0); check(rdV, gainM);
        wr(4'h4, 10001); rd(4'h4); check(rdV, ofsM);
        wr(4'h4, -10001); rd(4'h4); check(rdV, ofsM);
        $display("test refusal done");
        for (i = 0; i < 14; i++) begin
            c = nxt() % 4096; g = nxt() % 1001; o = int'(nxt() % 20001) - 10000;
            if (i == 0) begin c = 4095; g = 1000; o = -10000; end
            if (i == 1) begin c = 0; g = 0; o = 10000; end
            if (i == 2) begin c = 4095; g = 1; o = 10000; end
            wr(4'h0, g); wr(4'h4, o);
            conv(c);
        end
        $display("test scaling done");
        for (i = 0; i < 8; i++) begin
            wr(4'h8, nxt());
            @(posedge mclk);
            logicIn <= 8'(nxt());
            @(posedge mclk) #1;
            check(logicOut, logicIn ^ mskM[7:0]);
            rd(4'h8);
            check(rdV, mskM);
        end
        $display("test invert done");
        final_report();
    end
endmodule
